// ### include/acc_load_regs.svh
// constants of the accumulator load instruction group
// assumes a 10-bit instruction word, decoded in the execute stage against these opcodes
`ifndef ACC_LOAD_REGS_SVH
`define ACC_LOAD_REGS_SVH
// *****************
// opcodes, reset values and immediate field bounds
// *****************
`define OPC_LOAD_LCD_CTRL   10'h24A
`define OPC_LOAD_ADC_LOW    10'h249
`define OPC_LOAD_CLOCK_CTRL 10'h252
`define OPC_MEM_XOR_MASK    10'h3F0
`define OPC_MEM_XOR_BASE    10'h2C0
`define ACC_RESET           4'h0
`define X_RESET             4'h0
`define MEM_ADDR_RESET      6'h00
`define IMM_MSB             3
`define IMM_LSB             0
`endif

// ### include/acc_load_pkg.sv
// types of the accumulator load instruction group
// assumes acc_load_regs.svh for numeric constants
package acc_load_pkg;
  typedef logic [3:0] nibble_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } exec_state_e;
  typedef struct packed {
    exec_state_e state;
    nibble_t     acc;
    nibble_t     xreg;
    logic        done;
    logic        busy_err;
    logic [5:0]  mem_addr;
  } core_state_s;
endpackage

// ### logic/acc_load_exec.sv
// execute stage of the accumulator load instruction group
// assumes decode presents one instruction word per strobe, and memory data
// at the data pointer is valid combinationally in the same cycle
//
// Contract
// - lcd control load copies all four control bits into the accumulator.
// - adc low load puts result bits 1,0 into accumulator bits 3,2.
// - adc low load clears accumulator bits 1 and 0.
// - memory load copies nibble at data pointer into the accumulator.
// - memory load xors the 4-bit immediate into the x register.
// - clock control load copies all four control bits into the accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_regs.svh"
module acc_load_exec (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  instr_valid_in,
  input  wire logic [9:0]            instr_word_in,
  input  wire acc_load_pkg::nibble_t lcd_control_reg_in,
  input  wire acc_load_pkg::nibble_t clock_control_reg_in,
  input  wire logic                  adc_result_bit1_in,
  input  wire logic                  adc_result_bit0_in,
  input  wire acc_load_pkg::nibble_t mem_data_in,
  input  wire logic [5:0]            data_pointer_in,
  output logic [5:0]                 mem_addr_out,
  output acc_load_pkg::nibble_t      acc_out,
  output acc_load_pkg::nibble_t      xreg_out,
  output logic                       done_out,
  output logic                       carry_we_out,
  output logic                       skip_out
);
  import acc_load_pkg::*;

  // *****************
  // elaboration checks
  // *****************
  // a fixed word inside the memory block would decode twice, so refuse it here
  if ((`OPC_MEM_XOR_MASK & `OPC_MEM_XOR_BASE) != `OPC_MEM_XOR_BASE) begin : gen_base_check
    $error("memory load base has bits outside its mask");
  end
  if ((`OPC_MEM_XOR_MASK & 10'h00F) != 10'h000) begin : gen_imm_check
    $error("memory load mask covers the immediate field");
  end
  if ((`OPC_LOAD_LCD_CTRL & `OPC_MEM_XOR_MASK) == `OPC_MEM_XOR_BASE) begin : gen_lcd_check
    $error("lcd control load word falls in the memory block");
  end
  if ((`OPC_LOAD_ADC_LOW & `OPC_MEM_XOR_MASK) == `OPC_MEM_XOR_BASE) begin : gen_adc_check
    $error("adc low load word falls in the memory block");
  end
  if ((`OPC_LOAD_CLOCK_CTRL & `OPC_MEM_XOR_MASK) == `OPC_MEM_XOR_BASE) begin : gen_clk_check
    $error("clock control load word falls in the memory block");
  end
  if ((`OPC_LOAD_LCD_CTRL == `OPC_LOAD_ADC_LOW) ||
      (`OPC_LOAD_LCD_CTRL == `OPC_LOAD_CLOCK_CTRL) ||
      (`OPC_LOAD_ADC_LOW == `OPC_LOAD_CLOCK_CTRL)) begin : gen_unique_check
    $error("two load words share one encoding");
  end
  if ((`IMM_MSB - `IMM_LSB) != 3) begin : gen_field_check
    $error("immediate field is not four bits wide");
  end

  // *****************
  // decode
  // *****************
  logic    is_lcd;
  logic    is_adc;
  logic    is_mem;
  logic    is_clk;
  logic    is_group;
  nibble_t imm;
  nibble_t adc_nibble;

  // the immediate sits in the low field; only the memory form reads it
  assign is_lcd     = instr_valid_in && (instr_word_in == `OPC_LOAD_LCD_CTRL);
  assign is_adc     = instr_valid_in && (instr_word_in == `OPC_LOAD_ADC_LOW);
  assign is_clk     = instr_valid_in && (instr_word_in == `OPC_LOAD_CLOCK_CTRL);
  assign is_mem     = instr_valid_in &&
                      ((instr_word_in & `OPC_MEM_XOR_MASK) == `OPC_MEM_XOR_BASE);
  assign is_group   = is_lcd || is_adc || is_mem || is_clk;
  assign imm        = instr_word_in[`IMM_MSB:`IMM_LSB];
  // adc bits keep their order; the low half is cleared, not kept
  assign adc_nibble = {adc_result_bit1_in, adc_result_bit0_in, 2'b00};

  // *****************
  // state
  // *****************
  core_state_s cur;
  core_state_s next_cur;

  // memory is read combinationally, so a load finishes in the cycle it is taken
  always_comb begin
    next_cur          = cur;
    next_cur.busy_err = 1'b0;
    next_cur.mem_addr = data_pointer_in;
    case (cur.state)
      ST_IDLE: begin
        next_cur.state = is_group ? ST_EXEC : ST_IDLE;
      end
      ST_EXEC: begin
        next_cur.state = is_group ? ST_EXEC : ST_IDLE;
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
    if (is_lcd) begin
      next_cur.acc = lcd_control_reg_in;
    end else if (is_adc) begin
      next_cur.acc = adc_nibble;
    end else if (is_mem) begin
      next_cur.acc  = mem_data_in;
      next_cur.xreg = cur.xreg ^ imm;
    end else if (is_clk) begin
      next_cur.acc = clock_control_reg_in;
    end
    // one pulse per taken word; refused words leave accumulator and x alone
    next_cur.done = is_group;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur.state    <= ST_IDLE;
      cur.acc      <= `ACC_RESET;
      cur.xreg     <= `X_RESET;
      cur.done     <= 1'b0;
      cur.busy_err <= 1'b0;
      cur.mem_addr <= `MEM_ADDR_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // *****************
  // outputs
  // *****************
  assign mem_addr_out = cur.mem_addr;
  assign acc_out      = cur.acc;
  assign xreg_out     = cur.xreg;
  assign done_out     = cur.done;
  // group never writes carry nor requests a skip
  assign carry_we_out = cur.busy_err;
  assign skip_out     = cur.busy_err;

  // *****************
  // checks: transfers
  // *****************
  AST_LCD: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_lcd
    |=> acc_out == $past(lcd_control_reg_in))
    else $error("lcd load wrong");

  AST_ADC_HI: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_adc
    |=> acc_out[3:2] == {$past(adc_result_bit1_in), $past(adc_result_bit0_in)})
    else $error("adc high bits wrong");

  AST_ADC_BIT3: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_adc
    |=> acc_out[3] == $past(adc_result_bit1_in))
    else $error("adc bit order wrong in bit 3");

  AST_ADC_BIT2: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_adc
    |=> acc_out[2] == $past(adc_result_bit0_in))
    else $error("adc bit order wrong in bit 2");

  AST_ADC_LO: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_adc
    |=> acc_out[1:0] == 2'b00)
    else $error("adc low bits not cleared");

  AST_MEM: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_mem
    |=> acc_out == $past(mem_data_in))
    else $error("memory load wrong");

  // the antecedent skips the release edge, where the register still holds reset
  AST_ADDR: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !reset_in
    |=> mem_addr_out == $past(data_pointer_in))
    else $error("memory address does not follow the data pointer");

  AST_CLK: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_clk
    |=> acc_out == $past(clock_control_reg_in))
    else $error("clock load wrong");

  // *****************
  // checks: x register
  // *****************
  AST_XOR: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_mem
    |=> xreg_out == ($past(xreg_out) ^ $past(instr_word_in[3:0])))
    else $error("x xor wrong");

  AST_X_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !is_mem
    |=> $stable(xreg_out))
    else $error("x changed without memory load");

  AST_X_ZERO_IMM: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_mem && (imm == 4'h0)
    |=> $stable(xreg_out))
    else $error("x changed by a zero immediate");

  AST_X_FULL_IMM: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_mem && (imm == 4'hF)
    |=> xreg_out == ~$past(xreg_out))
    else $error("x not inverted by an all ones immediate");

  // *****************
  // checks: timing
  // *****************
  AST_ONE_CYCLE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_group
    |=> done_out)
    else $error("not one cycle");

  AST_DONE_ONLY: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !is_group
    |=> !done_out)
    else $error("done without a taken word");

  AST_DONE_PULSE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_group ##1 !is_group
    |=> !done_out)
    else $error("done stands longer than one cycle");

  AST_BACK_TO_BACK: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_group ##1 is_group
    |=> done_out)
    else $error("second of two adjacent loads lost");

  AST_ACC_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !is_group
    |=> $stable(acc_out))
    else $error("accumulator changed without a taken word");

  // *****************
  // checks: state
  // *****************
  AST_STATE_EXEC: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    is_group
    |=> cur.state == ST_EXEC)
    else $error("taken word did not enter execute");

  AST_STATE_IDLE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !is_group
    |=> cur.state == ST_IDLE)
    else $error("execute state without a taken word");

  AST_DONE_STATE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    done_out
    |-> cur.state == ST_EXEC)
    else $error("done outside execute");

  // *****************
  // checks: side outputs
  // *****************
  AST_NO_SKIP: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    done_out
    |-> !skip_out && !carry_we_out)
    else $error("skip or carry touched");

  AST_NO_CARRY: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !carry_we_out)
    else $error("carry write requested");

  AST_NO_SKIP_EVER: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !skip_out)
    else $error("skip requested");

  AST_BUSY_CLEAR: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !cur.busy_err)
    else $error("error flag raised");
endmodule // acc_load_exec
`default_nettype wire

// ### verif/accumulator_load_instructions_test.sv
// self-checking bench of the accumulator load instruction group
// assumes the execute stage answers one cycle after each taken word
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_regs.svh"
module accumulator_load_instructions_test;
  import acc_load_pkg::*;
  logic        ref_clk_in = 1'b0, reset_in = 1'b1, instr_valid_in = 1'b0;
  logic        adc_result_bit1_in = 1'b0, adc_result_bit0_in = 1'b0;
  logic [9:0]  instr_word_in = 10'h000;
  nibble_t     lcd_control_reg_in = 4'h0, clock_control_reg_in = 4'h0, mem_data_in = 4'h0;
  logic [5:0]  data_pointer_in = 6'h00, mem_addr_out;
  nibble_t     acc_out, xreg_out, acc_m, x_m;
  logic        done_out, carry_we_out, skip_out;
  logic [13:0] note;
  logic [13:0] notes[$];
  logic [31:0] lfsr = 32'hc57f_d1d3;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  acc_load_exec acc_load_exec_inst (.ref_clk_in, .reset_in, .instr_valid_in, .instr_word_in,
    .lcd_control_reg_in, .clock_control_reg_in, .adc_result_bit1_in, .adc_result_bit0_in,
    .mem_data_in, .data_pointer_in, .mem_addr_out, .acc_out, .xreg_out, .done_out,
    .carry_we_out, .skip_out);
  always #2 ref_clk_in = ~ref_clk_in;
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk_nib(input string what, input nibble_t exp, input nibble_t got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_addr(input string what, input logic [5:0] exp, input logic [5:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // refused words (0x24b, and 0x2d0 just past the memory range) and idle cycles leave no note
  task automatic run(input logic [31:0] r);
    logic [2:0] k;
    k = r[2:0];
    instr_word_in <= k == 0 ? `OPC_LOAD_LCD_CTRL : k == 1 ? `OPC_LOAD_ADC_LOW :
      k == 3 ? `OPC_LOAD_CLOCK_CTRL : k == 4 ? 10'h24B : k == 5 ? 10'h2D0 :
      (`OPC_MEM_XOR_BASE | {6'h00, r[7:4]});
    instr_valid_in <= r[31:30] != 2'b00;
    lcd_control_reg_in <= r[11:8];
    adc_result_bit1_in <= r[13];
    adc_result_bit0_in <= r[12];
    clock_control_reg_in <= r[19:16];
    mem_data_in <= r[23:20];
    data_pointer_in <= r[29:24];
    if (r[31:30] != 2'b00 && k != 3'd4 && k != 3'd5) begin
      acc_m = k == 0 ? r[11:8] : k == 1 ? {r[13:12], 2'b00} : k == 3 ? r[19:16] : r[23:20];
      if (k != 0 && k != 1 && k != 3) x_m = x_m ^ r[7:4];
      notes.push_back({acc_m, x_m, r[29:24]});
    end
  endtask
  initial begin
    for (int t = 0; t < 2; t++) begin
      reset_in <= 1'b1;
      instr_valid_in <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      acc_m = `ACC_RESET;
      x_m = `X_RESET;
      for (int i = 0; i < 400; i++) begin
        @(posedge ref_clk_in);
        lfsr = step(lfsr);
        run(lfsr);
      end
      @(posedge ref_clk_in);
      instr_valid_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      chk_flag("pending_results", 1'b0, notes.size() != 0);
      $display("test random_mix %0d done", t);
    end
    wrap_up();
  end
  // one-cycle latency: a missing or late done leaves notes behind or misaligns them
  always @(negedge ref_clk_in) begin
    cycles++;
    chk_flag("carry_we", 1'b0, carry_we_out);
    chk_flag("skip", 1'b0, skip_out);
    if (done_out !== 1'b1) chk_flag("done", 1'b0, done_out);
    else if (notes.size() == 0) chk_flag("spurious_done", 1'b0, done_out);
    else begin
      note = notes.pop_front();
      chk_nib("acc", note[13:10], acc_out);
      chk_nib("xreg", note[9:6], xreg_out);
      chk_addr("mem_addr", note[5:0], mem_addr_out);
    end
    if (cycles > 2000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule // accumulator_load_instructions_test
`default_nettype wire
